// ---- logic/fgp_pkg.sv ----
package fgp_pkg;
    localparam int unsigned PIN_COUNT = 5;
    localparam logic [7:0] OFF_PIN_DATA = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_DRIVE_ENABLE = 8'h04;
    localparam logic [7:0] OFF_ALT_FUNC_SELECT = 8'h08;
    localparam logic [7:0] OFF_RESERVED = 8'h10;
    localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h2c;
    localparam logic [7:0] OFF_INPUT_PATH_ENABLE = 8'h38;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
    localparam logic [7:0] OFF_STOP_CONTROL = 8'h48;
    localparam logic [7:0] REG_FIELD_MASK = 8'hff;
    localparam logic [4:0] RESET_BITS = 5'h00;
    localparam int unsigned TIMER_OUT_BIT = 4;
    localparam int unsigned IRQ_COUNT = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] pin_data;
        logic [7:0] output_drive_enable;
        logic [7:0] alternate_function_select;
        logic [7:0] pullup_enable;
        logic [7:0] input_path_enable;
    } fgp_cfg_s;

    typedef struct packed {
        logic [4:0] o;
        logic [4:0] oe;
        logic [4:0] pu;
    } fgp_pad_s;
endpackage

// ---- logic/fgp_pin_path.sv ----
`timescale 1ns/1ps
`default_nettype none
module fgp_pin_path (
    input wire logic [4:0] i_pad_level,
    input wire logic [4:0] i_input_enable_bits,
    input wire logic [4:0] i_alt_select,
    input wire logic i_stop_mode,
    input wire logic i_pin_drive_in_stop,
    output logic [4:0] o_gated_in,
    output logic [3:0] o_irq_lines
);
    logic [4:0] gated;
    always_comb begin
        // a blocked input reads constant zero
        gated = i_pad_level & i_input_enable_bits;
        o_gated_in = gated;
        for (int k = 0; k < 4; k++) begin
            if (i_stop_mode) begin
                // in stop only selected pins pass, whatever the drive setting
                o_irq_lines[k] = gated[k] & i_alt_select[k];
            end else begin
                o_irq_lines[k] = gated[k];
            end
        end
    end
endmodule // fgp_pin_path
`default_nettype wire

// ---- logic/fgp_port.sv ----
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fgp_port (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [4:0] i_pad_in,
    output logic [4:0] o_pad_out,
    output logic [4:0] o_pad_oe,
    output logic [4:0] o_pad_pullup,
    input wire logic i_timer_ch6_output,
    input wire logic i_stop_mode,
    output logic [3:0] o_ext_irq,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////
    // register state
    fgp_pkg::fgp_cfg_s cfg, next_cfg;
    logic [3:0] irq_status, next_irq_status;
    logic [3:0] irq_mask, next_irq_mask;
    logic pin_drive_in_stop, next_pin_drive_in_stop;
    logic [7:0] aw_addr, next_aw_addr;
    logic aw_full, next_aw_full;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic w_full, next_w_full;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic [3:0] irq_prev, next_irq_prev;
    fgp_pkg::fgp_pad_s pad, next_pad;
    logic [3:0] ext_irq, next_ext_irq;
    logic irq, next_irq;
    logic aw_ready, next_aw_ready;
    logic w_ready, next_w_ready;
    logic ar_ready, next_ar_ready;

    logic [4:0] gated_in;
    logic [3:0] irq_lines;

    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            fgp_pkg::OFF_PIN_DATA, fgp_pkg::OFF_OUTPUT_DRIVE_ENABLE,
            fgp_pkg::OFF_ALT_FUNC_SELECT, fgp_pkg::OFF_PULLUP_ENABLE,
            fgp_pkg::OFF_INPUT_PATH_ENABLE, fgp_pkg::OFF_IRQ_STATUS,
            fgp_pkg::OFF_IRQ_MASK, fgp_pkg::OFF_STOP_CONTROL: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    fgp_pin_path u_pin_path (
        .i_pad_level(i_pad_in),
        .i_input_enable_bits(cfg.input_path_enable[4:0]),
        .i_alt_select(cfg.alternate_function_select[4:0]),
        .i_stop_mode(i_stop_mode),
        .i_pin_drive_in_stop(pin_drive_in_stop),
        .o_gated_in(gated_in),
        .o_irq_lines(irq_lines)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus and registers
    logic do_write;
    logic [3:0] irq_rise;
    always_comb begin
        next_cfg = cfg;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_pin_drive_in_stop = pin_drive_in_stop;
        next_aw_addr = aw_addr;
        next_aw_full = aw_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_w_full = w_full;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_irq_prev = irq_lines;
        irq_rise = irq_lines & ~irq_prev;
        if (i_awvalid && !aw_full) begin
            next_aw_full = 1'b1;
            next_aw_addr = i_awaddr;
        end
        if (i_wvalid && !w_full) begin
            next_w_full = 1'b1;
            next_w_data = i_wdata;
            next_w_strb = i_wstrb;
        end
        if (bvalid && i_bready) begin
            next_bvalid = 1'b0;
        end
        do_write = aw_full && w_full && !bvalid;
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_mapped(aw_addr) ? fgp_pkg::RESP_OKAY : fgp_pkg::RESP_SLVERR;
            if (w_strb[0]) begin
                case (aw_addr)
                    fgp_pkg::OFF_PIN_DATA: next_cfg.pin_data = w_data[7:0];
                    fgp_pkg::OFF_OUTPUT_DRIVE_ENABLE: next_cfg.output_drive_enable = w_data[7:0];
                    fgp_pkg::OFF_ALT_FUNC_SELECT: next_cfg.alternate_function_select = w_data[7:0];
                    fgp_pkg::OFF_PULLUP_ENABLE: next_cfg.pullup_enable = w_data[7:0];
                    fgp_pkg::OFF_INPUT_PATH_ENABLE: next_cfg.input_path_enable = w_data[7:0];
                    fgp_pkg::OFF_IRQ_STATUS: next_irq_status = irq_status & ~w_data[3:0];
                    fgp_pkg::OFF_IRQ_MASK: next_irq_mask = w_data[3:0];
                    fgp_pkg::OFF_STOP_CONTROL: next_pin_drive_in_stop = w_data[0];
                    default: ;
                endcase
            end
        end
        // hardware set wins over a same-cycle clear
        next_irq_status = next_irq_status | irq_rise;
        if (rvalid && i_rready) begin
            next_rvalid = 1'b0;
        end
        if (i_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = addr_mapped(i_araddr) ? fgp_pkg::RESP_OKAY : fgp_pkg::RESP_SLVERR;
            case (i_araddr)
                fgp_pkg::OFF_PIN_DATA: next_rdata = {24'h000000, cfg.pin_data[7:5], gated_in};
                fgp_pkg::OFF_OUTPUT_DRIVE_ENABLE: next_rdata = {24'h000000, cfg.output_drive_enable};
                fgp_pkg::OFF_ALT_FUNC_SELECT: next_rdata = {24'h000000, cfg.alternate_function_select};
                fgp_pkg::OFF_PULLUP_ENABLE: next_rdata = {24'h000000, cfg.pullup_enable};
                fgp_pkg::OFF_INPUT_PATH_ENABLE: next_rdata = {24'h000000, cfg.input_path_enable};
                fgp_pkg::OFF_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
                fgp_pkg::OFF_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
                fgp_pkg::OFF_STOP_CONTROL: next_rdata = {31'h00000000, pin_drive_in_stop};
                default: next_rdata = 32'h00000000;
            endcase
        end
        next_aw_ready = !next_aw_full;
        next_w_ready = !next_w_full;
        next_ar_ready = !next_rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // pins
    logic drive_halt;
    always_comb begin
        // stop with drive-halt set releases every driver
        drive_halt = i_stop_mode && pin_drive_in_stop;
        next_pad.o = cfg.pin_data[4:0];
        if (cfg.alternate_function_select[fgp_pkg::TIMER_OUT_BIT]) begin
            next_pad.o[fgp_pkg::TIMER_OUT_BIT] = i_timer_ch6_output;
        end
        next_pad.oe = drive_halt ? 5'h00 : cfg.output_drive_enable[4:0];
        next_pad.pu = cfg.pullup_enable[4:0];
        next_ext_irq = irq_lines;
        next_irq = |(irq_status & irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg <= '0;
            irq_status <= 4'h0;
            irq_mask <= 4'h0;
            pin_drive_in_stop <= 1'b0;
            aw_addr <= 8'h00;
            aw_full <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            w_full <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
            irq_prev <= 4'h0;
            pad <= '0;
            ext_irq <= 4'h0;
            irq <= 1'b0;
            aw_ready <= 1'b1;
            w_ready <= 1'b1;
            ar_ready <= 1'b1;
        end else if (i_ce) begin
            cfg <= next_cfg;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            pin_drive_in_stop <= next_pin_drive_in_stop;
            aw_addr <= next_aw_addr;
            aw_full <= next_aw_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            w_full <= next_w_full;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            irq_prev <= next_irq_prev;
            pad <= next_pad;
            ext_irq <= next_ext_irq;
            irq <= next_irq;
            aw_ready <= next_aw_ready;
            w_ready <= next_w_ready;
            ar_ready <= next_ar_ready;
        end
    end

    assign o_awready = aw_ready;
    assign o_wready = w_ready;
    assign o_bvalid = bvalid;
    assign o_bresp = bresp;
    assign o_arready = ar_ready;
    assign o_rvalid = rvalid;
    assign o_rdata = rdata;
    assign o_rresp = rresp;
    assign o_pad_out = pad.o;
    assign o_pad_oe = pad.oe;
    assign o_pad_pullup = pad.pu;
    assign o_ext_irq = ext_irq;
    assign o_irq = irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_RESET_PLAIN: assert property (@(posedge i_clk) $rose(i_rstn) |-> (pad.oe == 5'h00 && pad.pu == 5'h00))
        else $error("pins not plain after reset");
    AST_OE_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !i_stop_mode) |=> (pad.oe == $past(cfg.output_drive_enable[4:0])))
        else $error("output enable mismatch");
    AST_PU_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ce |=> (pad.pu == $past(cfg.pullup_enable[4:0])))
        else $error("pull-up mismatch");
    AST_STOP_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_stop_mode) |=> (ext_irq == $past(i_pad_in[3:0] & cfg.input_path_enable[3:0]
        & cfg.alternate_function_select[3:0])))
        else $error("stop interrupt path wrong");
    AST_RUN_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !i_stop_mode) |=> (ext_irq == $past(i_pad_in[3:0] & cfg.input_path_enable[3:0])))
        else $error("run interrupt path wrong");
    AST_BLOCKED_INPUT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (gated_in & ~cfg.input_path_enable[4:0]) == 5'h00)
        else $error("blocked input leaks");
    AST_READ_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (!i_rstn)
        rvalid |-> (rdata[31:8] == 24'h000000))
        else $error("upper read bits not zero");
    AST_READ_INPUT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_arvalid && !rvalid && i_araddr == fgp_pkg::OFF_PIN_DATA)
        |=> (rdata[4:0] == $past(i_pad_in & cfg.input_path_enable[4:0])))
        else $error("data read wrong");
    AST_TIMER_OUT: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && cfg.alternate_function_select[4]) |=> (pad.o[4] == $past(i_timer_ch6_output)))
        else $error("timer output not routed");
    AST_HALT_RELEASES: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_stop_mode && pin_drive_in_stop) |=> (pad.oe == 5'h00))
        else $error("drivers not released in stop");
    AST_STATUS_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && irq_rise != 4'h0) |=> ((irq_status & $past(irq_rise)) == $past(irq_rise)))
        else $error("interrupt edge lost");
    AST_GATED_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        i_ce |=> ((ext_irq & ~$past(cfg.input_path_enable[3:0])) == 4'h0))
        else $error("interrupt from blocked input");
    AST_PAD_DATA: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !cfg.alternate_function_select[4]) |=> (pad.o == $past(cfg.pin_data[4:0])))
        else $error("pin output not from latch");
    AST_UNMAPPED_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_arvalid && !rvalid && i_araddr == fgp_pkg::OFF_RESERVED)
        |=> (rresp == fgp_pkg::RESP_SLVERR && rdata == 32'h00000000))
        else $error("unmapped read not refused");
    AST_WRITE_ANSWERS: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ce && aw_full && w_full && !bvalid) |=> bvalid)
        else $error("write not answered");
endmodule // fgp_port
`default_nettype wire

// ---- test/fgp_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fgp_board_model (
    input wire logic i_clk,
    input wire logic [4:0] i_pad_out,
    input wire logic [4:0] i_pad_oe,
    input wire logic [4:0] i_pad_pullup,
    input wire logic [4:0] i_board_en,
    input wire logic [4:0] i_board_val,
    output logic [4:0] o_level
);
    logic [4:0] float_pat = 5'h0a;
    // a pin nobody drives and nothing pulls up wanders every cycle
    always_ff @(posedge i_clk) begin
        float_pat <= ~float_pat;
    end
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (i_pad_oe[i]) o_level[i] = i_pad_out[i];
            else if (i_board_en[i]) o_level[i] = i_board_val[i];
            else if (i_pad_pullup[i]) o_level[i] = 1'b1;
            else o_level[i] = float_pat[i];
        end
    end
endmodule // fgp_board_model
`default_nettype wire

// ---- test/fgp_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fgp_port_tb_top;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic timer = 1'b0, stop = 1'b0, ce = 1'b1;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [4:0] board_en = 5'h00, board_val = 5'h00;
    wire logic awready, wready, bvalid, arready, rvalid, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [4:0] pad_in, pad_out, pad_oe, pad_pu;
    wire logic [3:0] ext_irq;
    logic [7:0] offs [5] = '{fgp_pkg::OFF_PIN_DATA, fgp_pkg::OFF_OUTPUT_DRIVE_ENABLE,
        fgp_pkg::OFF_ALT_FUNC_SELECT, fgp_pkg::OFF_PULLUP_ENABLE, fgp_pkg::OFF_INPUT_PATH_ENABLE};
    localparam logic [1:0] OK = fgp_pkg::RESP_OKAY;
    int n_errors = 0;
    int cmp_count = 0;
    initial forever #50 i_clk = ~i_clk;
    fgp_port dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pad_pullup(pad_pu),
        .i_timer_ch6_output(timer), .i_stop_mode(stop), .o_ext_irq(ext_irq), .o_irq(irq));
    fgp_board_model board (.i_clk(i_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pad_pullup(pad_pu),
        .i_board_en(board_en), .i_board_val(board_val), .o_level(pad_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done = 0;
        int t = 0;
        @(posedge i_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done && t < 100) begin
            @(posedge i_clk);
            t++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk(32'(bresp), 32'(er));
                bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) n_errors++;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        bit done = 0;
        int t = 0;
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done && t < 100) begin
            @(posedge i_clk);
            t++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk(rdata, exp);
                chk(32'(rresp), 32'(er));
                rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) n_errors++;
    endtask
    task automatic give_verdict();
        $display("mismatches %0d of %0d compares", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 5; i++) rd(offs[i], 32'h0, OK);
        chk(32'({pad_out, pad_oe, pad_pu, ext_irq, irq}), 32'h0);
    endtask
    task automatic t_regs();
        for (int i = 1; i < 5; i++) begin
            wr(offs[i], 32'hffffffff, OK);
            rd(offs[i], 32'h000000ff, OK);
        end
        repeat (2) @(posedge i_clk);
        chk(32'({pad_oe, pad_pu}), 32'h3ff);
        wr(offs[0], 32'h0000000a, OK);
        rd(offs[0], 32'h0000000a, OK);
        timer <= 1'b1;
        repeat (2) @(posedge i_clk);
        rd(offs[0], 32'h0000001a, OK);
        wr(offs[2], 32'h0, OK);
        repeat (2) @(posedge i_clk);
        chk(32'(pad_out), 32'h0a);
    endtask
    task automatic t_input();
        wr(offs[1], 32'h0, OK);
        board_en <= 5'h1f;
        board_val <= 5'h15;
        repeat (2) @(posedge i_clk);
        chk(32'(pad_oe), 32'h0);
        rd(offs[0], 32'h00000015, OK);
        wr(offs[4], 32'h0, OK);
        board_en <= 5'h00;
        rd(offs[0], 32'h0, OK);
        repeat (4) begin
            @(posedge i_clk);
            chk(32'(ext_irq), 32'h0);
        end
    endtask
    task automatic t_irq();
        board_en <= 5'h1f;
        board_val <= 5'h00;
        wr(offs[4], 32'h1, OK);
        wr(fgp_pkg::OFF_IRQ_MASK, 32'h1, OK);
        wr(fgp_pkg::OFF_IRQ_STATUS, 32'hf, OK);
        rd(fgp_pkg::OFF_IRQ_STATUS, 32'h0, OK);
        board_val <= 5'h01;
        repeat (4) @(posedge i_clk);
        chk(32'({ext_irq, irq}), 32'h03);
        wr(fgp_pkg::OFF_IRQ_STATUS, 32'h1, OK);
        repeat (2) @(posedge i_clk);
        chk(32'(irq), 32'h0);
        wr(fgp_pkg::OFF_IRQ_MASK, 32'h0, OK);
        board_val <= 5'h00;
        repeat (2) @(posedge i_clk);
        board_val <= 5'h01;
        repeat (4) @(posedge i_clk);
        chk(32'(irq), 32'h0);
        rd(fgp_pkg::OFF_IRQ_STATUS, 32'h1, OK);
    endtask
    task automatic t_stop();
        wr(offs[1], 32'h1e, OK);
        wr(fgp_pkg::OFF_STOP_CONTROL, 32'h1, OK);
        stop <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk(32'({pad_oe, ext_irq}), 32'h0);
        wr(offs[2], 32'h1, OK);
        repeat (3) @(posedge i_clk);
        chk(32'({pad_oe, ext_irq}), 32'h01);
        stop <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(32'(pad_oe), 32'h1e);
    endtask
    task automatic t_strobe();
        wstrb <= 4'he;
        wr(offs[3], 32'h0, OK);
        wstrb <= 4'hf;
        rd(offs[3], 32'h000000ff, OK);
    endtask
    task automatic t_ce();
        ce <= 1'b0;
        board_val <= 5'h00;
        repeat (3) @(posedge i_clk);
        chk(32'(ext_irq), 32'h1);
        ce <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(32'(ext_irq), 32'h0);
    endtask
    task automatic t_rerst();
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset();
        t_regs();
        t_strobe();
        wr(fgp_pkg::OFF_RESERVED, 32'h1, fgp_pkg::RESP_SLVERR);
        rd(fgp_pkg::OFF_RESERVED, 32'h0, fgp_pkg::RESP_SLVERR);
        t_input();
        t_irq();
        t_stop();
        t_ce();
        t_rerst();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        give_verdict();
    end
endmodule // fgp_port_tb_top
`default_nettype wire
